// ==== bench/cwr_restore_seq_properties.sv ====
// port assertions for the restore sequencer
`timescale 1ns/1ps
module cwr_restore_seq_properties #(
  parameter int unsigned SETTLE_CYCLES = 20,
  parameter bit STOP_AT_INDEX = 1'b0
) (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic power_ok, // power monitor
  input wire logic restore_cmd, // restore request
  input wire cwr_pkg::cwr_sense_t sense_pins, // sensors
  input wire cwr_pkg::cwr_drive_t drive, // servo commands
  input wire logic [cwr_pkg::WPOS_W-1:0] wheel_pos, // wheel position
  input wire logic busy, // running
  input wire logic strobe_enable, // strobes allowed
  input wire logic ready_ok, // ready allowed
  input wire logic done // completion
);
  import cwr_pkg::*;

  logic [2:0] cstep_seen;
  logic cstep_last;

  // carriage step pulses on the pins after the origin sensor released, per forward move
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cstep_seen <= 3'h0;
      cstep_last <= 1'b0;
    end else begin
      cstep_last <= sense_pins.car_step;
      if (!drive.car_forward) begin
        cstep_seen <= 3'h0;
      end else if (sense_pins.car_step && !cstep_last && !sense_pins.car_home) begin
        cstep_seen <= 3'(cstep_seen + 3'h1);
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_ready_blocked: assert property (ready_ok == !busy && strobe_enable == !busy)
    else $error("ready or strobe not tied to busy");
  chk_ready_moving: assert property (
    (drive != '0 || done) |-> !ready_ok && !strobe_enable)
    else $error("ready raised while sequence active");
  chk_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_done_stopped: assert property (done |-> drive == '0)
    else $error("drives active at done");
  chk_done_zero: assert property (
    done |-> wheel_pos == (STOP_AT_INDEX ? 8'h00 : 8'h1e))
    else $error("wheel stop offset wrong");
  chk_wheel_after: assert property (drive.whl_enable |-> !drive.car_enable)
    else $error("wheel homing during carriage homing");
  chk_rev_slow: assert property (
    drive.car_reverse |-> drive.car_enable && drive.car_slow)
    else $error("reverse not slow");
  chk_whl_speed: assert property (drive.whl_enable |-> drive.whl_cw
    && drive.whl_velocity == WHEEL_SEEK_COUNTS)
    else $error("wheel direction or velocity wrong");
  chk_home_stop: assert property ($rose(sense_pins.car_home) && drive.car_reverse
    |-> ##[1:4] !drive.car_enable)
    else $error("carriage servo not off at origin");
  chk_settle_wait: assert property ($fell(drive.car_reverse)
    |-> (!drive.car_forward)[*8] ##[10:20] drive.car_forward)
    else $error("forward move not after settle delay");
  chk_car_first: assert property ($rose(busy) |-> ##[0:2] drive.car_reverse)
    else $error("sequence did not open with carriage reverse");
  chk_car_steps: assert property ($fell(drive.car_forward) |-> cstep_seen == 3'h2)
    else $error("carriage steps past origin not two");
  cov_done: cover property (done);
  cov_wheel: cover property (drive.whl_enable);
  cov_rerun: cover property (done ##1 busy);
endmodule : cwr_restore_seq_properties

bind cwr_restore_seq cwr_restore_seq_properties #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .STOP_AT_INDEX(STOP_AT_INDEX)) cwr_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .power_ok(power_ok), .restore_cmd(restore_cmd), .sense_pins(sense_pins), .drive(drive),
  .wheel_pos(wheel_pos), .busy(busy), .strobe_enable(strobe_enable),
  .ready_ok(ready_ok), .done(done));

// ==== bench/cwr_servo_model.sv ====
// carriage and wheel servo stand-in that answers the drive commands with sensor pins
`timescale 1ns/1ps
module cwr_servo_model (
  input wire logic core_clk, // clock
  input wire cwr_pkg::cwr_drive_t drive, // servo commands
  output cwr_pkg::cwr_sense_t sense // sensor pins
);
  import cwr_pkg::*;
  logic [7:0] t = 8'h00;
  logic home = 1'b0;
  always @(posedge core_clk) begin
    t <= t + 8'h01;
    if (drive.car_enable && drive.car_reverse && t[3]) home <= 1'b1;
    if (drive.car_enable && drive.car_forward && t[3]) home <= 1'b0;
  end
  // index sits between step edges so a clear never meets a count
  assign sense = {home, drive.car_forward & !home & t[1],
                  drive.whl_cw & (t[5:1] == 5'h02), drive.whl_cw & t[1]};
endmodule : cwr_servo_model

// ==== bench/tb.sv ====
// self-checking bench for the restore sequencer and its stop-at-index variant
`timescale 1ns/1ps
module tb;
  import cwr_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_ok = 1'b0;
  logic restore_cmd = 1'b0;
  cwr_sense_t sns, sns_v;
  cwr_drive_t drv, drv_v;
  logic [WPOS_W-1:0] pos, pos_v;
  logic [WPOS_W-1:0] pos_vd = 8'hff;
  logic busy, strb, rdy, done, done_v;
  int fail_count = 0;
  int checks = 0;
  cwr_restore_seq #(.SETTLE_CYCLES(20)) cwr_restore_seq_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .power_ok(power_ok), .restore_cmd(restore_cmd), .sense_pins(sns),
    .drive(drv), .wheel_pos(pos), .busy(busy), .strobe_enable(strb), .ready_ok(rdy),
    .done(done));
  cwr_servo_model cwr_servo_model_i (.core_clk(core_clk), .drive(drv), .sense(sns));
  cwr_restore_seq #(.SETTLE_CYCLES(20), .STOP_AT_INDEX(1'b1)) cwr_restore_seq_idx_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .power_ok(power_ok), .restore_cmd(restore_cmd),
    .sense_pins(sns_v), .drive(drv_v), .wheel_pos(pos_v), .busy(), .strobe_enable(),
    .ready_ok(), .done(done_v));
  cwr_servo_model cwr_servo_model_idx_i (.core_clk(core_clk), .drive(drv_v), .sense(sns_v));
  always @(posedge core_clk) if (done_v) pos_vd <= pos_v;
  initial forever #2 core_clk = ~core_clk;

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // bounded wait for the completion pulse, then judge the stop point
  task automatic finish_run();
    int n;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 3000) begin
        chk(1'b0, "no completion");
        end_sim();
      end
    end
    chk(pos === 8'h1e, "wheel stop position");
    chk(drv === '0 && rdy === 1'b0, "drives or ready at done");
    chk(pos_vd === 8'h00, "variant stop position");
    @(posedge core_clk);
    #1;
    chk(done === 1'b0, "done not single");
  endtask : finish_run

  task automatic pulse_restore();
    @(posedge core_clk) restore_cmd <= 1'b1;
    repeat (2) @(posedge core_clk);
    restore_cmd <= 1'b0;
  endtask : pulse_restore

  task automatic test_power();
    @(posedge core_clk) power_ok <= 1'b1;
    finish_run();
    chk(rdy === 1'b1 && strb === 1'b1, "ready not restored");
    $display("test_power done");
  endtask : test_power

  task automatic test_restore();
    pulse_restore();
    repeat (4) @(posedge core_clk);
    #1;
    chk(busy === 1'b1 && rdy === 1'b0 && strb === 1'b0, "not blocked");
    chk(drv.car_reverse === 1'b1 && drv.whl_enable === 1'b0, "carriage not first");
    pos_vd <= 8'hff;
    finish_run();
    $display("test_restore done");
  endtask : test_restore

  task automatic test_rerun();
    pulse_restore();
    repeat (10) @(posedge core_clk);
    pos_vd <= 8'hff;
    pulse_restore();
    finish_run();
    repeat (3) @(posedge core_clk);
    #1;
    chk(busy === 1'b1, "queued restore lost");
    // the variant's rerun must land its own stop point again
    pos_vd <= 8'hff;
    finish_run();
    $display("test_rerun done");
  endtask : test_rerun

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_power();
    test_restore();
    test_rerun();
    end_sim();
  end
endmodule : tb

// ==== inc/cwr_pkg.sv ====
// constants and types for the carriage and wheel restore sequencer
package cwr_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SETTLE_MS = 100;
  localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned CNT_W = 32;
  localparam logic [1:0] CAR_EXTRA_STEPS = 2'd2;
  localparam logic [2:0] INDEX_PULSES = 3'd3;
  localparam logic [5:0] WHEEL_EXTRA_COUNTS = 6'd30;
  localparam logic [5:0] WHEEL_SEEK_COUNTS = 6'd30;
  localparam int unsigned WPOS_W = 8;
  localparam logic [WPOS_W-1:0] WPOS_ZERO = 8'h00;

  typedef enum logic [2:0] {
    CWR_IDLE = 3'b000,
    CWR_CAR_REV = 3'b001,
    CWR_CAR_WAIT = 3'b011,
    CWR_CAR_FWD = 3'b010,
    CWR_CAR_STEP = 3'b110,
    CWR_WHL_SEEK = 3'b111,
    CWR_WHL_STEP = 3'b101,
    CWR_DONE = 3'b100
  } cwr_state_t;

  typedef struct packed {
    logic car_enable;
    logic car_reverse;
    logic car_forward;
    logic car_slow;
    logic whl_enable;
    logic whl_cw;
    logic [5:0] whl_velocity;
  } cwr_drive_t;

  typedef struct packed {
    logic car_home;
    logic car_step;
    logic whl_index;
    logic whl_step;
  } cwr_sense_t;
endpackage : cwr_pkg

// ==== rtl/cwr_restore_seq.sv ====
// restore sequencer: carriage homing followed by print wheel homing
//
// Contract
// - carriage homing always runs first
// - slow reverse; servo off at origin sensor
// - wait fixed delay, then move forward
// - two steps past sensor release, then stop
// - wheel homing only after carriage done
// - clockwise wheel at thirty-count move velocity
// - clear wheel position on third index
// - thirty more counts after clear, stop
// - variant stops at index, skips offset
// - start on power-up or restore command
// - block strobes, ready false while running
`timescale 1ns/1ps
module cwr_restore_seq #(
  parameter int unsigned SETTLE_CYCLES = cwr_pkg::SETTLE_CYC,
  parameter bit STOP_AT_INDEX = 1'b0
) (
  input wire logic core_clk, // system clock, 250 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic power_ok, // power monitor level, async
  input wire logic restore_cmd, // controller restore level, async
  input wire cwr_pkg::cwr_sense_t sense_pins, // raw sensor pins
  output cwr_pkg::cwr_drive_t drive, // servo commands
  output logic [cwr_pkg::WPOS_W-1:0] wheel_pos, // absolute wheel position
  output logic busy, // sequence running
  output logic strobe_enable, // strobe latches allowed
  output logic ready_ok, // ready outputs may be true
  output logic done // one-cycle completion pulse
);
  import cwr_pkg::*;

  typedef struct packed {
    cwr_state_t state;
    logic [CNT_W-1:0] timer;
    logic [1:0] car_steps;
    logic [2:0] index_cnt;
    logic [5:0] whl_counts;
    logic [WPOS_W-1:0] wpos;
    logic pwr_prev;
    logic rst_prev;
    logic idx_prev;
    logic cstep_prev;
    logic wstep_prev;
    logic pending;
    logic done;
    cwr_drive_t drive;
  } cwr_st_t;

  cwr_st_t st_r;
  cwr_st_t st_nxt;
  logic [5:0] sync_q;
  cwr_sense_t sense;
  logic pwr_s;
  logic rst_s;
  logic idx_edge;
  logic cstep_edge;
  logic wstep_edge;
  logic start;
  logic [5:0] whl_target;

  cwr_sync #(.W(6)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({power_ok, restore_cmd, sense_pins}),
    .sync_out(sync_q)
  );

  assign pwr_s = sync_q[5];
  assign rst_s = sync_q[4];
  assign sense = cwr_sense_t'(sync_q[3:0]);
  assign idx_edge = sense.whl_index && !st_r.idx_prev;
  assign cstep_edge = sense.car_step && !st_r.cstep_prev;
  assign wstep_edge = sense.whl_step && !st_r.wstep_prev;
  // power coming good or a restore request both start the sequence
  assign start = (pwr_s && !st_r.pwr_prev) || (rst_s && !st_r.rst_prev);
  // wheel stops at the sensor itself on the variant builds
  assign whl_target = STOP_AT_INDEX ? 6'd0 : WHEEL_EXTRA_COUNTS;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pwr_prev = pwr_s;
    st_nxt.rst_prev = rst_s;
    st_nxt.idx_prev = sense.whl_index;
    st_nxt.cstep_prev = sense.car_step;
    st_nxt.wstep_prev = sense.whl_step;
    st_nxt.done = 1'b0;
    if (wstep_edge) begin
      st_nxt.wpos = WPOS_W'(st_r.wpos + 1'b1);
    end
    // a request during a run restarts cleanly once the run ends
    if (start && st_r.state != CWR_IDLE) begin
      st_nxt.pending = 1'b1;
    end
    case (st_r.state)
      CWR_IDLE: begin
        st_nxt.drive = '0;
        if (start || st_r.pending) begin
          st_nxt.pending = 1'b0;
          st_nxt.state = CWR_CAR_REV;
          st_nxt.drive.car_enable = 1'b1;
          st_nxt.drive.car_reverse = 1'b1;
          st_nxt.drive.car_slow = 1'b1;
        end
      end
      CWR_CAR_REV: begin
        if (sense.car_home) begin
          st_nxt.drive = '0;
          st_nxt.timer = '0;
          st_nxt.state = CWR_CAR_WAIT;
        end
      end
      CWR_CAR_WAIT: begin
        if (st_r.timer >= CNT_W'(SETTLE_CYCLES - 1)) begin
          st_nxt.drive.car_enable = 1'b1;
          st_nxt.drive.car_forward = 1'b1;
          st_nxt.state = CWR_CAR_FWD;
        end else begin
          st_nxt.timer = CNT_W'(st_r.timer + 1'b1);
        end
      end
      CWR_CAR_FWD: begin
        if (!sense.car_home) begin
          // a step seen together with the sensor release is already the first one
          st_nxt.car_steps = cstep_edge ? 2'h1 : 2'h0;
          st_nxt.state = CWR_CAR_STEP;
        end
      end
      CWR_CAR_STEP: begin
        if (cstep_edge) begin
          st_nxt.car_steps = 2'(st_r.car_steps + 1'b1);
          if (2'(st_r.car_steps + 1'b1) == CAR_EXTRA_STEPS) begin
            st_nxt.drive = '0;
            // carriage fully home before the wheel is touched
            st_nxt.drive.whl_enable = 1'b1;
            st_nxt.drive.whl_cw = 1'b1;
            st_nxt.drive.whl_velocity = WHEEL_SEEK_COUNTS;
            st_nxt.index_cnt = '0;
            st_nxt.state = CWR_WHL_SEEK;
          end
        end
      end
      CWR_WHL_SEEK: begin
        if (idx_edge) begin
          st_nxt.index_cnt = 3'(st_r.index_cnt + 1'b1);
          if (3'(st_r.index_cnt + 1'b1) == INDEX_PULSES) begin
            st_nxt.wpos = WPOS_ZERO;
            st_nxt.whl_counts = '0;
            if (whl_target == 6'd0) begin
              st_nxt.drive = '0;
              st_nxt.state = CWR_DONE;
            end else begin
              st_nxt.state = CWR_WHL_STEP;
            end
          end
        end
      end
      CWR_WHL_STEP: begin
        if (wstep_edge) begin
          st_nxt.whl_counts = 6'(st_r.whl_counts + 1'b1);
          if (6'(st_r.whl_counts + 1'b1) == whl_target) begin
            st_nxt.drive = '0;
            st_nxt.state = CWR_DONE;
          end
        end
      end
      CWR_DONE: begin
        st_nxt.done = 1'b1;
        st_nxt.state = CWR_IDLE;
      end
      default: begin
        st_nxt.state = CWR_IDLE;
        st_nxt.drive = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive = st_r.drive;
  assign wheel_pos = st_r.wpos;
  assign done = st_r.done;
  // ready stays low through the done pulse, so acceptance reopens only after it
  assign busy = (st_r.state != CWR_IDLE) || st_r.pending || st_r.done;
  assign strobe_enable = !busy;
  assign ready_ok = !busy;
endmodule : cwr_restore_seq

// ==== rtl/cwr_sync.sv ====
// two flip-flop synchroniser for the power, restore and sensor inputs
`timescale 1ns/1ps
module cwr_sync #(
  parameter int unsigned W = 4
) (
  input wire logic core_clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic [W-1:0] async_in, // raw pins
  output logic [W-1:0] sync_out // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cwr_sync_st_t;
  cwr_sync_st_t st_r;
  cwr_sync_st_t st_nxt;
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sync_out = st_r.stable;
endmodule : cwr_sync
